// File: src/cpu_address_mode_decoder.sv
/*
 * Addressing-mode sequencer: forms effective addresses, sizes instructions and runs the
 * memory side of read/modify/write, bit set/clear and bit test-and-branch instructions.
 * Assumes memory returns read data the cycle after a read strobe and takes writes at once;
 * the register/ALU side supplies the modified byte for general read/modify/write.
 */
`timescale 1ns/10ps
// Operation
// - immediate: operand follows opcode, two bytes
// - direct: second byte addresses page zero
// - extended: two bytes form address, three bytes
// - taken branch: pc plus 2 plus signed offset
// - untaken branch uses zero offset
// - indexed no offset: index is address, one byte
// - indexed 8-bit: byte plus index, two bytes
// - indexed 16-bit: word plus index, three bytes
// - bit set/clear: low bits pick bit
// - bit test-branch: page-zero byte, bit, offset
// - tested bit is copied into carry
// - implied: no address, one byte long
// - read/modify/write stores result to same place
// - test instruction reads but never writes back
// - bit set/clear never writes direction registers
// - ram, io and rom reachable in page zero
// - five instruction classes decoded
// - register/memory pairs register with memory operand
// - jump and call have no register operand
module cpu_address_mode_decoder (
    input  wire logic                       clk,
    input  wire logic                       rstn,
    input  wire logic                       start,
    input  wire addr_mode_pkg::instr_type   instr,
    input  wire logic [15:0]                pc,
    input  wire logic [7:0]                 index,
    input  wire logic                       branch_cond,
    input  wire logic [7:0]                 mem_rdata,
    input  wire logic [7:0]                 rmw_result,
    output addr_mode_pkg::bus_type          bus,
    output addr_mode_pkg::result_type       result,
    output addr_mode_pkg::decode_type       decoded,
    output logic [7:0]                      operand,
    output logic                            busy,
    output logic                            done
);
    import addr_mode_pkg::*;

    typedef struct packed {
        phase_type  phase;
        decode_type dec;
        instr_type  ins;
        logic [15:0] pc;
        logic [7:0] operand;
        bus_type    bus;
        result_type res;
    } core_type;

    core_type   core;
    core_type   next_core;
    decode_type dec_now;

    opcode_classifier u_classifier (
        .opcode (instr.opcode),
        .decode (dec_now)
    );

    function automatic logic [15:0] rel_target(input logic [15:0] base, input logic [15:0] step,
                                               input logic [7:0] rel, input logic taken);
        logic [15:0] offset;
        offset = taken ? {{8{rel[7]}}, rel} : 16'h0000;
        return base + step + offset;
    endfunction

    function automatic logic is_ddr(input logic [15:0] a);
        return (a[15:8] == PAGE_ZERO_HIGH) && (a[7:0] >= DDR_FIRST) && (a[7:0] <= DDR_LAST);
    endfunction

    function automatic logic [15:0] calc_ea(input decode_type d, input instr_type i,
                                            input logic [15:0] p, input logic [7:0] x,
                                            input logic taken);
        logic [15:0] ea;
        ea = 16'h0000;
        unique case (d.mode)
            mode_immediate:       ea = p + PC_STEP_IMM;
            mode_direct,
            mode_bit_set_clear,
            mode_bit_test_branch: ea = {PAGE_ZERO_HIGH, i.byte2};
            mode_extended:        ea = {i.byte2, i.byte3};
            mode_relative:        ea = rel_target(p, PC_STEP_REL, i.byte2, taken);
            mode_indexed0:        ea = {PAGE_ZERO_HIGH, x};
            mode_indexed8:        ea = {PAGE_ZERO_HIGH, x} + {PAGE_ZERO_HIGH, i.byte2};
            mode_indexed16:       ea = {i.byte2, i.byte3} + {PAGE_ZERO_HIGH, x};
            mode_implied:         ea = 16'h0000;
        endcase
        return ea;
    endfunction

    logic       needs_mem;
    logic       bit_now;
    logic       btb_taken;
    logic [7:0] bit_mask;

    assign needs_mem = (dec_now.iclass == class_bit_manipulation)
                       || (dec_now.iclass == class_read_modify_write
                           && dec_now.mode != mode_implied);
    assign bit_mask  = 8'h01 << core.dec.bit_index;
    assign bit_now   = |(mem_rdata & bit_mask);
    assign btb_taken = bit_now ^ core.dec.bit_clear;

    always_comb begin
        next_core = core;
        next_core.bus.rd = 1'b0;
        next_core.bus.wr = 1'b0;
        unique case (core.phase)
            ph_idle: begin
                if (start) begin
                    next_core.dec = dec_now;
                    next_core.ins = instr;
                    next_core.pc  = pc;
                    next_core.res = '0;
                    next_core.res.length = dec_now.length;
                    next_core.res.ea_valid = (dec_now.mode != mode_implied);
                    next_core.res.effective_address =
                        calc_ea(dec_now, instr, pc, index, branch_cond);
                    next_core.res.branch_taken = (dec_now.mode == mode_relative) && branch_cond;
                    next_core.res.next_pc = (dec_now.mode == mode_relative)
                        ? rel_target(pc, PC_STEP_REL, instr.byte2, branch_cond)
                        : pc + {14'h0000, dec_now.length};
                    if (needs_mem) begin
                        next_core.bus.addr = calc_ea(dec_now, instr, pc, index, 1'b0);
                        next_core.bus.rd   = 1'b1;
                        next_core.phase    = ph_read;
                    end else begin
                        next_core.phase = ph_finish;
                    end
                end
            end
            ph_read: begin
                next_core.phase = ph_capture;
            end
            ph_capture: begin
                next_core.operand = mem_rdata;
                if (core.dec.mode == mode_bit_test_branch) begin
                    next_core.res.carry        = bit_now;
                    next_core.res.carry_write  = 1'b1;
                    next_core.res.branch_taken = btb_taken;
                    next_core.res.next_pc = rel_target(core.pc, PC_STEP_BTB,
                                                       core.ins.byte3, btb_taken);
                    next_core.phase = ph_finish;
                end else if (core.dec.mode == mode_bit_set_clear) begin
                    if (is_ddr(core.bus.addr)) begin
                        next_core.phase = ph_finish;
                    end else begin
                        next_core.bus.wdata = core.dec.bit_clear ? (mem_rdata & ~bit_mask)
                                                                 : (mem_rdata | bit_mask);
                        next_core.bus.wr = 1'b1;
                        next_core.phase  = ph_write;
                    end
                end else begin
                    next_core.phase = ph_modify;
                end
            end
            ph_modify: begin
                if (core.dec.is_test) begin
                    next_core.phase = ph_finish;
                end else begin
                    next_core.bus.wdata = rmw_result;
                    next_core.bus.wr    = 1'b1;
                    next_core.phase     = ph_write;
                end
            end
            ph_write: begin
                next_core.phase = ph_finish;
            end
            ph_finish: begin
                next_core.phase = ph_idle;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            core <= '0;
        end else begin
            core <= next_core;
        end
    end

    assign bus     = core.bus;
    assign result  = core.res;
    assign decoded = core.dec;
    assign operand = core.operand;
    assign busy    = (core.phase != ph_idle);
    assign done    = (core.phase == ph_finish);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_immediate_ea: assert property (
        start && !busy && dec_now.mode == mode_immediate
        |=> result.effective_address == $past(pc) + 16'h0001 && result.length == LEN_TWO)
        else $error("immediate address or length wrong");

    chk_direct_page: assert property (
        start && !busy && dec_now.mode == mode_direct
        |=> result.effective_address == {8'h00, $past(instr.byte2)})
        else $error("direct address not in page zero");

    chk_extended_ea: assert property (
        start && !busy && dec_now.mode == mode_extended
        |=> result.effective_address == {$past(instr.byte2), $past(instr.byte3)}
            && result.length == LEN_THREE)
        else $error("extended address wrong");

    chk_branch_target: assert property (
        start && !busy && dec_now.mode == mode_relative && branch_cond
        |=> result.next_pc == $past(pc) + 16'h0002 + {{8{$past(instr.byte2[7])}},
                                                     $past(instr.byte2)})
        else $error("taken branch target wrong");

    chk_untaken_branch: assert property (
        start && !busy && dec_now.mode == mode_relative && !branch_cond
        |=> result.next_pc == $past(pc) + 16'h0002 && !result.branch_taken)
        else $error("untaken branch moved");

    chk_index_add: assert property (
        start && !busy && dec_now.mode == mode_indexed8
        |=> result.effective_address == {8'h00, $past(index)} + {8'h00, $past(instr.byte2)})
        else $error("indexed sum wrong");

    chk_implied_len: assert property (
        start && !busy && dec_now.mode == mode_implied && !needs_mem
        |=> !result.ea_valid && result.length == LEN_ONE ##1 !busy)
        else $error("implied instruction misdecoded");

    chk_test_nowrite: assert property (
        bus.rd && decoded.is_test |-> (!bus.wr) [*4])
        else $error("test instruction wrote back");

    chk_rmw_sameaddr: assert property (
        bus.rd && decoded.iclass == class_read_modify_write && !decoded.is_test
        |-> ##3 bus.wr && bus.addr == $past(bus.addr, 3))
        else $error("write-back not to read address");

    chk_ddr_protect: assert property (
        bus.wr && decoded.mode == mode_bit_set_clear |-> !is_ddr(bus.addr))
        else $error("bit set/clear hit direction register");

    chk_carry_copy: assert property (
        core.phase == ph_capture && decoded.mode == mode_bit_test_branch
        |=> result.carry == $past(bit_now) && result.carry_write && done)
        else $error("tested bit not in carry");

    chk_done_bound: assert property (
        start && !busy |-> ##[1:5] done)
        else $error("instruction never finished");

    cov_bit_test_taken: cover property (
        done && decoded.mode == mode_bit_test_branch && result.branch_taken);
    cov_bit_set_write: cover property (bus.wr && decoded.mode == mode_bit_set_clear);
    cov_rmw_write: cover property (bus.wr && decoded.iclass == class_read_modify_write);
    cov_branch_taken: cover property (done && decoded.mode == mode_relative && result.branch_taken);

endmodule

// File: src/addr_mode_pkg.sv
/*
 * Shared types and constants for the operand addressing and instruction class logic.
 * Assumes one 100 MHz clock and an 8-bit memory bus that answers a read one cycle later.
 */
package addr_mode_pkg;

    localparam int          INSTR_COUNT     = 59;
    localparam logic [1:0]  LEN_ONE         = 2'h1;
    localparam logic [1:0]  LEN_TWO         = 2'h2;
    localparam logic [1:0]  LEN_THREE       = 2'h3;
    localparam logic [15:0] PC_STEP_REL     = 16'h0002;
    localparam logic [15:0] PC_STEP_BTB     = 16'h0003;
    localparam logic [15:0] PC_STEP_IMM     = 16'h0001;
    localparam logic [7:0]  PAGE_ZERO_HIGH  = 8'h00;
    localparam logic [15:0] PAGE_ZERO_LAST  = 16'h00FF;
    localparam int          ROM_IN_PAGE_ZERO = 128;
    localparam logic [7:0]  DDR_FIRST       = 8'h04;
    localparam logic [7:0]  DDR_LAST        = 8'h07;
    localparam logic [3:0]  LO_TEST         = 4'hD;
    localparam logic [3:0]  LO_JUMP         = 4'hC;
    localparam logic [3:0]  LO_CALL         = 4'hD;
    localparam logic [3:0]  LO_CMP_INDEX    = 4'h3;
    localparam logic [3:0]  LO_LOAD_INDEX   = 4'hE;
    localparam logic [3:0]  LO_STORE_INDEX  = 4'hF;
    localparam logic [3:0]  LO_BRANCH_CALL  = 4'hD;

    typedef enum logic [3:0] {
        mode_immediate, mode_direct, mode_extended, mode_relative, mode_indexed0,
        mode_indexed8, mode_indexed16, mode_bit_set_clear, mode_bit_test_branch,
        mode_implied
    } mode_type;

    typedef enum logic [2:0] {
        class_register_memory, class_read_modify_write, class_branch,
        class_bit_manipulation, class_control
    } class_type;

    typedef enum logic [2:0] {
        ph_idle, ph_read, ph_capture, ph_modify, ph_write, ph_finish
    } phase_type;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte2;
        logic [7:0] byte3;
    } instr_type;

    typedef struct packed {
        mode_type   mode;
        class_type  iclass;
        logic [1:0] length;
        logic       uses_reg;
        logic       uses_index;
        logic       is_test;
        logic       is_jump;
        logic [2:0] bit_index;
        logic       bit_clear;
    } decode_type;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
    } bus_type;

    typedef struct packed {
        logic [15:0] effective_address;
        logic        ea_valid;
        logic [15:0] next_pc;
        logic [1:0]  length;
        logic        carry;
        logic        carry_write;
        logic        branch_taken;
    } result_type;

endpackage

// File: src/opcode_classifier.sv
/*
 * Combinational opcode classifier: addressing mode, class, length and operand flags.
 * Assumes the opcode is stable for the cycle in which it is read.
 */
`timescale 1ns/10ps
module opcode_classifier (
    input  wire logic [7:0]                opcode,
    output addr_mode_pkg::decode_type       decode
);
    import addr_mode_pkg::*;

    logic [3:0] hi;
    logic [3:0] lo;

    assign hi = opcode[7:4];
    assign lo = opcode[3:0];

    always_comb begin
        decode            = '0;
        decode.mode       = mode_implied;
        decode.iclass     = class_control;
        decode.length     = LEN_ONE;
        decode.bit_index  = opcode[2:0];
        decode.bit_clear  = opcode[3];
        unique case (hi)
            4'h0: begin
                decode.mode   = mode_bit_test_branch;
                decode.iclass = class_bit_manipulation;
                decode.length = LEN_THREE;
            end
            4'h1: begin
                decode.mode   = mode_bit_set_clear;
                decode.iclass = class_bit_manipulation;
                decode.length = LEN_TWO;
            end
            4'h2: begin
                decode.mode   = mode_relative;
                decode.iclass = class_branch;
                decode.length = LEN_TWO;
            end
            4'h3, 4'h6: begin
                decode.mode   = (hi == 4'h3) ? mode_direct : mode_indexed8;
                decode.iclass = class_read_modify_write;
                decode.length = LEN_TWO;
            end
            4'h4, 4'h5: begin
                decode.iclass = class_read_modify_write;
            end
            4'h7: begin
                decode.mode   = mode_indexed0;
                decode.iclass = class_read_modify_write;
            end
            4'h8, 4'h9: begin
                decode.iclass = class_control;
            end
            4'hA: begin
                if (lo == LO_BRANCH_CALL) begin
                    decode.mode   = mode_relative;
                    decode.iclass = class_branch;
                end else begin
                    decode.mode   = mode_immediate;
                    decode.iclass = class_register_memory;
                end
                decode.length = LEN_TWO;
            end
            4'hB: begin
                decode.mode   = mode_direct;
                decode.iclass = class_register_memory;
                decode.length = LEN_TWO;
            end
            4'hC: begin
                decode.mode   = mode_extended;
                decode.iclass = class_register_memory;
                decode.length = LEN_THREE;
            end
            4'hD: begin
                decode.mode   = mode_indexed16;
                decode.iclass = class_register_memory;
                decode.length = LEN_THREE;
            end
            4'hE: begin
                decode.mode   = mode_indexed8;
                decode.iclass = class_register_memory;
                decode.length = LEN_TWO;
            end
            4'hF: begin
                decode.mode   = mode_indexed0;
                decode.iclass = class_register_memory;
            end
        endcase
        decode.is_test = (decode.iclass == class_read_modify_write) && (lo == LO_TEST);
        decode.is_jump = (decode.iclass == class_register_memory)
                         && (lo == LO_JUMP || lo == LO_CALL);
        decode.uses_reg = (decode.iclass == class_register_memory) && !decode.is_jump;
        decode.uses_index = decode.uses_reg
                            && (lo == LO_CMP_INDEX || lo == LO_LOAD_INDEX
                                || lo == LO_STORE_INDEX);
    end

endmodule

// File: test/mem_model.sv
/*
 * Behavioural memory and I/O space on the internal bus.
 * Assumes the decoder's one-cycle rd/wr strobes; read data follows one cycle after rd.
 */
`timescale 1ns/10ps
module mem_model (
    input  wire logic                   clk,
    input  wire addr_mode_pkg::bus_type bus,
    output logic [7:0]                  mem_rdata
);
    import addr_mode_pkg::*;
    logic [7:0] mem [0:65535];
    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem[a] = 8'(a) ^ 8'h5A;
        end
    end
    // data holds one cycle only, then toggles so a late capture is caught
    always @(posedge clk) begin
        if (bus.rd === 1'b1) begin
            mem_rdata <= mem[bus.addr];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
        if (bus.wr === 1'b1) begin
            mem[bus.addr] <= bus.wdata;
        end
    end
endmodule

// File: test/tb_top.sv
/*
 * Self-checking bench for the addressing-mode decoder.
 * Assumes mem_model on the far side, seeded with address xor 5A.
 */
`timescale 1ns/10ps
module tb_top;
    import addr_mode_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, start = 1'b0, branch_cond = 1'b0;
    instr_type   instr = '0;
    logic [15:0] pc = '0, waddr, raddr;
    logic [7:0]  index = '0, rmw_result = '0, mem_rdata, operand, wdata;
    bus_type     bus;
    result_type  result;
    decode_type  decoded;
    logic        busy, done;
    int          errors = 0, cmp_count = 0, wcount, rcount, lat;

    cpu_address_mode_decoder i_dut (.clk(clk), .rstn(rstn), .start(start), .instr(instr),
        .pc(pc), .index(index), .branch_cond(branch_cond), .mem_rdata(mem_rdata),
        .rmw_result(rmw_result), .bus(bus), .result(result), .decoded(decoded),
        .operand(operand), .busy(busy), .done(done));
    mem_model i_mem (.clk(clk), .bus(bus), .mem_rdata(mem_rdata));

    initial begin
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        if (bus.wr === 1'b1) begin
            wcount++;
            waddr = bus.addr;
            wdata = bus.wdata;
        end
        if (bus.rd === 1'b1) begin
            rcount++;
            raddr = bus.addr;
        end
    end

    function automatic logic [7:0] mval(input logic [7:0] a);
        return a ^ 8'h5A;
    endfunction
    task automatic stop_test();
        if (errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run(input logic [23:0] ins, input logic [15:0] p, input logic [7:0] x,
                       input logic c, input int hold);
        int n;
        n = 0;
        @(posedge clk);
        start <= 1'b1;
        instr <= ins;
        pc <= p;
        index <= x;
        branch_cond <= c;
        wcount = 0;
        rcount = 0;
        do begin
            @(posedge clk);
            if (n + 1 >= hold) start <= 1'b0;
            #1;
            n++;
        end while (done !== 1'b1 && n < 20);
        lat = n;
        cmp_val("done", 1, done);
    endtask
    task automatic chk_res(input logic ev, input logic [15:0] ea, input logic [1:0] len);
        cmp_val("ea_valid", ev, result.ea_valid);
        if (ev) cmp_val("effective_address", ea, result.effective_address);
        cmp_val("length", len, result.length);
    endtask

    task automatic t_reg_memory();
        run(24'hA67700, 16'h1234, 8'h00, 1'b0, 1);
        chk_res(1, 16'h1235, LEN_TWO);
        cmp_val("next_pc", 16'h1236, result.next_pc);
        cmp_val("iclass", 16'(class_register_memory), 16'(decoded.iclass));
        cmp_val("uses_reg", 1, decoded.uses_reg);
        cmp_val("uses_index", 0, decoded.uses_index);
        run(24'hAE1000, 16'h0300, 8'h00, 1'b0, 1);
        cmp_val("uses_index", 1, decoded.uses_index);
        run(24'hB69C00, 16'h0300, 8'h00, 1'b0, 1);
        chk_res(1, 16'h009C, LEN_TWO);
        run(24'hC61234, 16'h0300, 8'h00, 1'b0, 1);
        chk_res(1, 16'h1234, LEN_THREE);
        run(24'hBC4000, 16'h0300, 8'h00, 1'b0, 1);
        chk_res(1, 16'h0040, LEN_TWO);
        cmp_val("uses_reg", 0, decoded.uses_reg);
        cmp_val("is_jump", 1, decoded.is_jump);
        run(24'hCD1234, 16'h0300, 8'h00, 1'b0, 1);
        cmp_val("uses_reg", 0, decoded.uses_reg);
    endtask
    task automatic t_indexed();
        run(24'hF60000, 16'h0300, 8'hFF, 1'b0, 1);
        chk_res(1, 16'h00FF, LEN_ONE);
        run(24'hE6FF00, 16'h0300, 8'hFF, 1'b0, 1);
        chk_res(1, 16'h01FE, LEN_TWO);
        run(24'hD680F0, 16'h0300, 8'h90, 1'b0, 1);
        chk_res(1, 16'h8180, LEN_THREE);
    endtask
    task automatic t_branch();
        run(24'h208000, 16'h0400, 8'h00, 1'b1, 1);
        cmp_val("next_pc", 16'h0382, result.next_pc);
        cmp_val("taken", 1, result.branch_taken);
        chk_res(1, 16'h0382, LEN_TWO);
        run(24'h207F00, 16'h0400, 8'h00, 1'b1, 1);
        cmp_val("next_pc", 16'h0481, result.next_pc);
        cmp_val("iclass", 16'(class_branch), 16'(decoded.iclass));
        run(24'h207F00, 16'h0400, 8'h00, 1'b0, 1);
        cmp_val("next_pc", 16'h0402, result.next_pc);
        cmp_val("taken", 0, result.branch_taken);
    endtask
    task automatic t_implied();
        run(24'h4C0000, 16'h0500, 8'h00, 1'b0, 1);
        chk_res(0, 16'h0000, LEN_ONE);
        cmp_val("next_pc", 16'h0501, result.next_pc);
        cmp_val("accesses", 16'(rcount + wcount), 0);
        run(24'h830000, 16'h0500, 8'h00, 1'b0, 1);
        chk_res(0, 16'h0000, LEN_ONE);
        cmp_val("iclass", 16'(class_control), 16'(decoded.iclass));
        run(24'h800000, 16'h0500, 8'h00, 1'b0, 1);
        chk_res(0, 16'h0000, LEN_ONE);
    endtask
    task automatic t_bit_set_clear();
        logic [7:0] v;
        for (int i = 0; i < 16; i++) begin
            v = mval(8'h40 + 8'(i));
            v = (i < 8) ? v | (8'h01 << i) : v & ~(8'h01 << (i - 8));
            run({8'h10 + 8'(i), 8'h40 + 8'(i), 8'h00}, 16'h0600, 8'h00, 1'b0, 1);
            cmp_val("bit_wdata", v, wdata);
            cmp_val("bit_waddr", 16'h0040 + 16'(i), waddr);
            cmp_val("bit_writes", 16'(wcount), 1);
            cmp_val("bit_latency", 16'(lat), 4);
        end
        run(24'h150500, 16'h0600, 8'h00, 1'b0, 1);
        cmp_val("ddr_writes", 16'(wcount), 0);
        run(24'h1F0700, 16'h0600, 8'h00, 1'b0, 1);
        cmp_val("ddr_writes", 16'(wcount), 0);
        cmp_val("ddr_latency", 16'(lat), 3);
    endtask
    task automatic t_bit_test();
        logic [7:0] v;
        logic       b;
        for (int i = 0; i < 16; i++) begin
            v = mval(8'h60 + 8'(i));
            b = v[i % 8];
            run({8'(i), 8'h60 + 8'(i), 8'hF0}, 16'h0200, 8'h00, 1'b0, 1);
            cmp_val("carry", b, result.carry);
            cmp_val("carry_write", 1, result.carry_write);
            cmp_val("btb_next_pc", (b ^ (i >= 8)) ? 16'h01F3 : 16'h0203, result.next_pc);
            cmp_val("btb_raddr", 16'h0060 + 16'(i), raddr);
            cmp_val("btb_length", LEN_THREE, result.length);
            cmp_val("btb_writes", 16'(wcount), 0);
        end
    endtask
    task automatic t_rmw();
        @(posedge clk);
        rmw_result <= 8'hA5;
        run(24'h3C5000, 16'h0700, 8'h00, 1'b0, 3);
        cmp_val("operand", mval(8'h50), operand);
        cmp_val("rmw_waddr", 16'h0050, waddr);
        cmp_val("rmw_wdata", 16'h00A5, wdata);
        cmp_val("rmw_latency", 16'(lat), 5);
        @(posedge clk);
        rmw_result <= 8'h3C;
        run(24'h7C0000, 16'h0700, 8'h51, 1'b0, 1);
        cmp_val("rmw_waddr", 16'h0051, waddr);
        cmp_val("rmw_wdata", 16'h003C, wdata);
        run(24'h3D5200, 16'h0700, 8'h00, 1'b0, 1);
        cmp_val("tst_writes", 16'(wcount), 0);
        cmp_val("tst_latency", 16'(lat), 4);
        cmp_val("operand", mval(8'h52), operand);
    endtask

    initial begin
        #200000;
        errors++;
        stop_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        cmp_val("reset_state", 0, {busy, done, bus.rd, bus.wr});
        rstn <= 1'b1;
        t_reg_memory();
        t_indexed();
        t_branch();
        t_implied();
        t_bit_set_clear();
        t_bit_test();
        t_rmw();
        stop_test();
    end
endmodule
